// ### logic/redir_regs.vh
// Operation
// - Bits 10:8 hold delivery mode; codes 011 and 110 are reserved.
// - Fixed and lowest-priority modes follow the trigger sensitivity bit.
// - Modes 010, 100, 101, 111 are always edge, ignoring sensitivity.
// - Bits 7:0 hold the vector, reset zero, used in the message.
// - High word bits 31:24 become message address bits 19:12.
// - High word bits 23:16 become message address bits 11:4.
// - Twenty-four low/high pairs from index 10h, two apart, to 3Eh.
// - Bit 15 selects sensitivity: zero edge, one level.
// - Unmasked input edge or level sends message; masked drops, nothing pending.
`ifndef REDIR_REGS_VH
`define REDIR_REGS_VH
`define RT_FIRST_IDX 8'h10
`define RT_LAST_IDX 8'h3F
`define RT_ENTRIES 24
`define F_VEC_LSB 0
`define F_VEC_MSB 7
`define F_DELM_LSB 8
`define F_DELM_MSB 10
`define F_DSTM 11
`define F_DSTAT 12
`define F_POL 13
`define F_RIRR 14
`define F_SENS 15
`define F_MASK 16
`define F_NOFLUSH 17
`define LOW_RESET 18'h10000
`define HIGH_RESET 16'h0000
`define F_DID_LSB 24
`define F_EDID_LSB 16
`define DM_FIXED 3'h0
`define DM_LOWPRI 3'h1
`define MA_DID_LSB 12
`define MA_EDID_LSB 4
`define MA_DSTM 2
`define MD_LEVEL_ASSERT 14
`endif

// ### logic/redir_table.v
`timescale 1ns/1ps
`include "redir_regs.vh"
module redir_table #(
  parameter NUM_IRQ = `RT_ENTRIES,
  parameter [11:0] ADDR_BASE = 12'h000
)(
  input wire sys_clk, // Clock
  input wire rst_n, // Sync reset, active low
  input wire ce, // Clock enable
  input wire [7:0] reg_addr, // Word index of register
  input wire [31:0] reg_wdata, // Write data
  input wire reg_wr, // Write strobe
  input wire reg_rd, // Read strobe
  output reg [31:0] reg_rdata, // Read data
  output reg reg_rd_valid, // Read data valid
  input wire [NUM_IRQ-1:0] irq_in, // Interrupt inputs, active high
  input wire eoi_valid, // End of interrupt pulse
  input wire [7:0] eoi_vector, // Vector of the end of interrupt
  output reg msg_valid, // Message write pending
  output reg [31:0] msg_addr, // Message address
  output reg [31:0] msg_data, // Message data
  input wire msg_ready // Fabric takes the message
);
  // Only implemented low-word bits are stored
  reg [17:0] low_word [0:NUM_IRQ-1];
  // Only the two identifier bytes of the high word are stored
  reg [15:0] high_word [0:NUM_IRQ-1];
  reg [NUM_IRQ-1:0] rirr;
  reg [NUM_IRQ-1:0] pending;
  reg [NUM_IRQ-1:0] irq_prev;
  reg [NUM_IRQ-1:0] is_level;
  reg [NUM_IRQ-1:0] raw_event;
  reg [NUM_IRQ-1:0] next_pending;
  reg [NUM_IRQ-1:0] next_rirr;
  reg [31:0] rd_word;
  reg [31:0] next_addr;
  reg [31:0] next_data;
  reg sel_hit;
  reg [4:0] sel;
  reg [17:0] lw;
  reg [15:0] hw;
  reg [17:0] sel_low;
  reg [15:0] sel_high;
  wire hit;
  wire [7:0] rel_idx;
  wire [4:0] entry;
  wire in_range;
  wire take;
  wire issue;
  integer i;
  integer j;
  integer k;
  integer n;
  integer r;

  assign hit = (reg_addr >= `RT_FIRST_IDX) &&
    (reg_addr <= `RT_LAST_IDX);
  assign rel_idx = reg_addr - `RT_FIRST_IDX;
  assign entry = rel_idx[5:1];
  // Guards the table arrays if fewer entries are built
  assign in_range = hit && (entry < NUM_IRQ);
  // Output slot is free when empty or being taken this edge
  assign take = !msg_valid || msg_ready;
  assign issue = take && sel_hit;

  // Sensitivity only counts for fixed and lowest priority
  always @*
  begin
    for (i = 0; i < NUM_IRQ; i = i + 1)
    begin
      is_level[i] = low_word[i][`F_SENS] &&
        (low_word[i][`F_DELM_MSB:`F_DELM_LSB] == `DM_FIXED ||
         low_word[i][`F_DELM_MSB:`F_DELM_LSB] == `DM_LOWPRI);
    end
  end

  // Edge entries see a rising input, level entries a high one
  always @*
  begin
    for (j = 0; j < NUM_IRQ; j = j + 1)
    begin
      if (is_level[j])
        raw_event[j] = irq_in[j];
      else
        raw_event[j] = irq_in[j] && !irq_prev[j];
    end
  end

  always @*
  begin
    lw = 18'h00000;
    hw = 16'h0000;
    rd_word = 32'h0000_0000;
    if (in_range)
    begin
      lw = low_word[entry];
      hw = high_word[entry];
    end
    if (in_range && rel_idx[0])
      rd_word = {hw, 16'h0000};
    else if (in_range)
      rd_word = {14'h0000,
        lw[17:15],
        rirr[entry],
        lw[13],
        is_level[entry] && !lw[`F_MASK] && irq_in[entry],
        lw[11:0]};
  end

  // Lowest index wins; one message in flight at a time
  always @*
  begin
    sel_hit = 1'b0;
    sel = 5'h00;
    for (k = NUM_IRQ - 1; k >= 0; k = k - 1)
    begin
      if (pending[k])
      begin
        sel_hit = 1'b1;
        sel = k[4:0];
      end
    end
  end

  always @*
  begin
    next_pending = pending;
    next_rirr = rirr;
    for (n = 0; n < NUM_IRQ; n = n + 1)
    begin
      // Only level entries carry a remote acknowledge state
      if (!is_level[n])
        next_rirr[n] = 1'b0;
      else if (eoi_valid &&
               low_word[n][`F_VEC_MSB:`F_VEC_LSB] == eoi_vector)
        next_rirr[n] = 1'b0;
    end
    // After the clear, so an issue beats a same-cycle EOI
    if (issue)
    begin
      next_pending[sel] = 1'b0;
      if (is_level[sel])
        next_rirr[sel] = 1'b1;
    end
    // Uses next_rirr so a level entry is not sent twice
    for (n = 0; n < NUM_IRQ; n = n + 1)
    begin
      if (low_word[n][`F_MASK])
        next_pending[n] = 1'b0;
      else if (raw_event[n] && !(is_level[n] && next_rirr[n]))
        next_pending[n] = 1'b1;
    end
  end

  always @*
  begin
    sel_low = low_word[sel];
    sel_high = high_word[sel];
    next_addr = {ADDR_BASE,
      sel_high[15:8],
      sel_high[7:0],
      1'b0,
      sel_low[`F_DSTM],
      2'b00};
    next_data = {16'h0000,
      is_level[sel],
      1'b1,
      3'b000,
      sel_low[`F_DELM_MSB:`F_DELM_LSB],
      sel_low[`F_VEC_MSB:`F_VEC_LSB]};
  end

  // Read-only and unused bits are never stored
  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      for (r = 0; r < NUM_IRQ; r = r + 1)
      begin
        low_word[r] <= `LOW_RESET;
        high_word[r] <= `HIGH_RESET;
      end
    end
    else if (ce && reg_wr && in_range)
    begin
      if (rel_idx[0])
        high_word[entry] <= reg_wdata[31:16];
      else
        low_word[entry] <= {reg_wdata[17:15], 1'b0, reg_wdata[13],
          1'b0, reg_wdata[11:0]};
    end
  end

  // A read alongside a write returns the old contents
  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      reg_rdata <= 32'h0000_0000;
      reg_rd_valid <= 1'b0;
    end
    else if (ce)
    begin
      reg_rd_valid <= reg_rd;
      if (reg_rd)
        reg_rdata <= rd_word;
    end
  end

  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      rirr <= {NUM_IRQ{1'b0}};
      pending <= {NUM_IRQ{1'b0}};
      irq_prev <= {NUM_IRQ{1'b0}};
    end
    else if (ce)
    begin
      irq_prev <= irq_in;
      pending <= next_pending;
      rirr <= next_rirr;
    end
  end

  // Held until the fabric takes it; no queue behind the slot
  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      msg_valid <= 1'b0;
      msg_addr <= 32'h0000_0000;
      msg_data <= 32'h0000_0000;
    end
    else if (ce && take)
    begin
      msg_valid <= sel_hit;
      if (sel_hit)
      begin
        msg_addr <= next_addr;
        msg_data <= next_data;
      end
    end
  end
endmodule

// ### verif/redir_asserts.sv
`timescale 1ns/1ps
module redir_asserts(
  input wire sys_clk, rst_n, ce, reg_rd, reg_rd_valid, msg_valid, msg_ready,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_rdata, msg_addr, msg_data
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_rd_answer: assert property ($past(ce) |-> reg_rd_valid == $past(reg_rd))
    else $error("rd late");
  a_rd_unmapped: assert property (ce && reg_rd && reg_addr > 8'h3F |=>
    reg_rdata == 32'h0) else $error("unmapped rd");
  a_rdata_hold: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
    else $error("rdata moved");
  a_msg_hold: assert property (msg_valid && !msg_ready |=> msg_valid &&
    $stable({msg_addr, msg_data})) else $error("msg moved");
  a_addr_gaps: assert property (msg_valid |-> msg_addr[3] == 1'b0 &&
    msg_addr[1:0] == 2'h0) else $error("addr gaps");
  a_data_form: assert property (msg_valid |-> msg_data[14] &&
    msg_data[31:16] == 16'h0) else $error("data form");
  a_edge_modes: assert property (msg_valid && msg_data[10:9] != 2'h0 |->
    !msg_data[15]) else $error("edge as level");
  a_quiet_start: assert property ($rose(rst_n) |-> !msg_valid [*2])
    else $error("early msg");
  cover property (reg_rd_valid);
  cover property (msg_valid && !msg_ready);
  cover property (msg_valid && msg_data[15]);
endmodule
bind redir_table redir_asserts redir_asserts_inst(.*);

// ### verif/fabric_model.sv
`timescale 1ns/1ps
module fabric_model(
  input wire sys_clk, // Clock
  input wire slow, // Take every other cycle
  output reg msg_ready = 1'b0 // Fabric takes the message
);
  // Slow fabric takes every other cycle
  always @(posedge sys_clk)
    msg_ready <= !slow || !msg_ready;
endmodule

// ### verif/redir_table_tb_top.sv
`timescale 1ns/1ps
module redir_table_tb_top;
  reg sys_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, slow = 0;
  reg eoi_valid = 1'b0, ce = 1'b1;
  reg [2:0] k;
  reg [7:0] reg_addr = 8'h00, eoi_vector = 8'h00, v, h;
  reg [31:0] reg_wdata = 32'h0, e;
  reg [23:0] irq_in = 24'h0;
  wire [31:0] reg_rdata, msg_addr, msg_data;
  wire reg_rd_valid, msg_valid, msg_ready;
  integer seed = 32'h226f71e1, n_errors = 0, n_tests = 0, m, n;
  always #4 sys_clk = ~sys_clk;
  redir_table redir_table_inst(.*);
  fabric_model fabric_model_inst(.*);
  task chk(input [31:0] g, x);
    begin
      n_tests = n_tests + 1;
      if (g !== x)
      begin
        n_errors = n_errors + 1;
        $display("ERROR %0t got %h exp %h", $time, g, x);
      end
    end
  endtask
  task acc(input [7:0] a, input [31:0] d, input w);
    begin
      @(posedge sys_clk);
      {reg_addr, reg_wdata, reg_wr, reg_rd} <= {a, d, w, !w};
      @(posedge sys_clk);
      {reg_wr, reg_rd} <= 2'h0;
      @(negedge sys_clk);
      if (!w)
        chk(reg_rdata, d);
    end
  endtask
  function [31:0] exp_data(input [2:0] k, input [7:0] x);
    exp_data = {16'h0, k < 3'h2, 1'b1, 3'h0, k, x};
  endfunction
  task end_sim;
    begin
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  initial
  begin
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    acc(8'h10, 32'h10000, 0);
    acc(8'h40, 32'h0, 0);
    for (m = 0; m < 8; m = m + 1)
    begin
      e = $random(seed);
      {v, h} = e[15:0];
      // Reserved codes are never written
      k = m[2:0];
      if (k == 3'h3 || k == 3'h6)
        k = k - 3'h1;
      acc(8'h11 + 6 * m, {h, ~h, 16'h0}, 1);
      // Sensitivity set on all modes, so edge-only modes must ignore it
      acc(8'h10 + 6 * m, {16'h0, 5'h10, k, v}, 1);
      @(posedge sys_clk);
      irq_in[3 * m] <= 1'b1;
      slow <= m[0];
      @(posedge sys_clk);
      irq_in[3 * m] <= 1'b0;
      for (n = 0; n < 40 && !(msg_valid && msg_ready); n = n + 1)
        @(negedge sys_clk);
      chk(msg_addr, {12'h0, h, ~h, 4'h0});
      chk(msg_data, exp_data(k, v));
      $display("mode %0d done", m);
    end
    @(posedge sys_clk);
    irq_in[23] <= 1'b1;
    repeat (4) @(negedge sys_clk);
    chk(msg_valid, 32'h0);
    // Held level input: one message, then blocked until EOI
    acc(8'h13, 32'hA5C3_0000, 1);
    acc(8'h12, 32'h0000_805A, 1);
    @(posedge sys_clk);
    irq_in[1] <= 1'b1;
    for (n = 0; n < 40 && !(msg_valid && msg_ready); n = n + 1)
      @(negedge sys_clk);
    chk(msg_addr, 32'h000A_5C30);
    chk(msg_data, exp_data(3'h0, 8'h5A));
    repeat (6) @(negedge sys_clk);
    chk(msg_valid, 32'h0);
    acc(8'h12, 32'h0000_D05A, 0);
    @(posedge sys_clk);
    {irq_in[1], eoi_valid, eoi_vector} <= {1'b0, 1'b1, 8'h5A};
    @(posedge sys_clk);
    eoi_valid <= 1'b0;
    acc(8'h12, 32'h0000_805A, 0);
    $display("level done");
    // Clock enable low freezes the read answer
    @(posedge sys_clk);
    {ce, reg_addr, reg_rd} <= {1'b0, 8'h12, 1'b1};
    @(posedge sys_clk);
    {ce, reg_rd} <= 2'b10;
    @(negedge sys_clk);
    chk(reg_rd_valid, 32'h0);
    $display("freeze done");
    end_sim;
  end
  initial
  begin
    #20000;
    n_errors = n_errors + 1;
    end_sim;
  end
endmodule
